// *** hw/limit_window.sv ***
// Purpose: compares a value against an upper and a lower limit
// Assumes: unsigned values, limits inclusive
// Notes: purely combinational
`timescale 1ns/100ps
module limit_window #(
  parameter int WIDTH = 12
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] upper,
  input wire logic [WIDTH-1:0] lower,
  output logic above,
  output logic below
);
  // ==========================================================================
  // parameter check
  if (WIDTH < 1) begin : g_bad_width
    $error("limit_window width must be at least one");
  end

  // strict comparisons, a value equal to a limit is inside
  assign above = value > upper;
  assign below = value < lower;
endmodule

// *** hw/monitor_cfg_pkg.sv ***
// Purpose: shared constants for the sensor monitor configuration bank
// Assumes: word addressed memory map, one 32-bit word per address
// Notes: field positions are bit numbers inside a 32-bit word
package monitor_cfg_pkg;
  // ==========================================================================
  // word addresses
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h11;
  localparam logic [7:0] ADDR_TEMP = 8'h12;
  localparam logic [7:0] ADDR_TRIM = 8'h13;
  localparam logic [7:0] ADDR_AREA = 8'h14;
  localparam logic [7:0] ADDR_TIMING = 8'h15;
  localparam logic [7:0] ADDR_XLIM = 8'h16;
  localparam logic [7:0] ADDR_YLIM = 8'h17;
  localparam logic [7:0] ADDR_XNORM = 8'h18;
  localparam logic [7:0] ADDR_YNORM = 8'h19;
  localparam logic [7:0] ADDR_CAP = 8'h1a;
  localparam logic [7:0] ADDR_CALIB = 8'h1b;
  localparam logic [7:0] ADDR_RECORDS = 8'h1c;
  localparam logic [7:0] ADDR_TOP = 8'hff;

  // ==========================================================================
  // configuration word store, index = address - ADDR_FLAGS
  localparam int CFG_WORDS = 11;
  localparam int CI_TEMP = 1;
  localparam int CI_TRIM = 2;
  localparam int CI_AREA = 3;
  localparam int CI_TIMING = 4;
  localparam int CI_XLIM = 5;
  localparam int CI_YLIM = 6;
  localparam int CI_XNORM = 7;
  localparam int CI_YNORM = 8;
  localparam int CI_CAP = 9;
  localparam int CI_CALIB = 10;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // writable bits per word, index 10 first
  localparam logic [CFG_WORDS-1:0][31:0] CFG_MASK = {
    32'h0fff_0fff, 32'h7f7f_7f7f, 32'h0fff_0fff, 32'h0fff_0fff, 32'h0fff_0fff, 32'h0fff_0fff,
    32'hffff_00ff, 32'hffff_8fff, 32'h3fff_ffff, 32'hffff_ffff, 32'h0fff_037f};

  // ==========================================================================
  // field positions
  localparam int FLAG_TEMP_EN_BIT = 0;
  localparam int FLAG_X_EN_BIT = 1;
  localparam int FLAG_Y_EN_BIT = 2;
  localparam int FLAG_IRQ_MODE_BIT = 3;
  localparam int UPPER_BOUND_LSB = 24;
  localparam int LOWER_BOUND_MSB = 24;
  localparam int LOWER_BOUND_LSB = 16;
  localparam int SKIP_BATT_BIT = 29;
  localparam int OFFS_SIGN_BIT = 28;
  localparam int KEEP_AWAKE_BIT = 15;
  localparam int AVG_EXP_MSB = 11;
  localparam int AVG_EXP_LSB = 8;
  localparam int START_DELAY_LSB = 16;
  localparam int HI12_MSB = 27;
  localparam int HI12_LSB = 16;
  localparam int LO12_MSB = 11;
  localparam int BYTE3_LSB = 24;
  localparam int BYTE2_LSB = 16;
  localparam int BYTE1_LSB = 8;
  localparam int Y_NEG_CAP_LSB = 24;
  localparam int Y_POS_CAP_LSB = 16;
  localparam int X_POS_CAP_LSB = 8;
  localparam int CAP_FIELD_W = 7;

  // ==========================================================================
  // timing: one monitor tick is one minute
  localparam longint CLK_HZ = 200_000_000;
  localparam longint TICK_SECONDS = 60;
  localparam longint TICK_CYCLES = CLK_HZ * TICK_SECONDS;
  localparam int TICK_W = 34;
  localparam int NORM_FRAC_BITS = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_WAIT = 2'b10,
    ST_SAMPLE = 2'b11
  } mon_state_e;
endpackage

// *** hw/sensor_monitor_config_bank.sv ***
// Purpose: configuration words, status word and log area of the sensor monitor
// Assumes: word port on ref_clk, one read or write per cycle, one-cycle read latency
// Notes: start_delay and interval_duration count one-minute ticks
// How it works
// R1 - upper and lower temperature bounds from word 12h
// R2 - clock frequency and temperature trims from 12h
// R3 - battery test unless skip bit set
// R4 - signed temperature offset correction from 13h
// R5 - two oscillator trims from word 13h
// R6 - interrupt record count from 14h
// R7 - alarm pulls low above threshold
// R8 - keep awake bit blocks power down
// R9 - average two-power samples per value
// R10 - no logging beyond log end word
// R11 - wait start delay before monitoring
// R12 - measure once per interval duration
// R13 - X signal compared with its limits
// R14 - Y signal compared with its limits
// R15 - X normalised by gain and offset
// R16 - Y normalised by gain and offset
// R17 - Y capacitances output from word 1Ah
// R18 - X capacitances output from word 1Ah
// R19 - calibration constants held in 1Bh
// R20 - record layout count minutes Y X
// R21 - log words follow interrupt records
// R22 - config write clears status word
// R23 - outband logs only out-of-bounds samples
// R24 - record write sets external flag
// R25 - reserved bits ignored, read zero
`timescale 1ns/100ps
module sensor_monitor_config_bank
  import monitor_cfg_pkg::*;
#(
  parameter longint TICK_CYCLES_P = monitor_cfg_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  input wire logic start_cmd,
  input wire logic start_outband,
  input wire logic battery_ok,
  input wire logic [11:0] temp_raw,
  input wire logic temp_valid,
  input wire logic [11:0] x_raw,
  input wire logic [11:0] y_raw,
  input wire logic ext_valid,
  output logic sample_req,
  output logic alarm_pull_low,
  output logic keep_awake,
  output logic power_down_ok,
  output logic [7:0] clock_freq_trim,
  output logic [7:0] clock_temp_trim,
  output logic [7:0] osc_trim_a,
  output logic [7:0] osc_trim_b,
  output logic [monitor_cfg_pkg::CAP_FIELD_W-1:0] x_pos_cap,
  output logic [monitor_cfg_pkg::CAP_FIELD_W-1:0] x_neg_cap,
  output logic [monitor_cfg_pkg::CAP_FIELD_W-1:0] y_pos_cap,
  output logic [monitor_cfg_pkg::CAP_FIELD_W-1:0] y_neg_cap,
  output logic [11:0] x_calibration,
  output logic [11:0] y_calibration
);
  import monitor_cfg_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    mon_state_e st;
    logic [CFG_WORDS-1:0][31:0] cfg;
    logic [7:0] irq_cnt;
    logic overflow;
    logic batt_err;
    logic alarm;
    logic outband;
    logic ext_irq;
    logic [7:0] mon_cnt;
    logic [TICK_W-1:0] tick_div;
    logic [15:0] delay_cnt;
    logic [7:0] minutes;
    logic [7:0] ivl_idx;
    logic [15:0] smp_cnt;
    logic [26:0] acc;
    logic x_prev;
    logic y_prev;
    logic batt_s1;
    logic batt_s2;
    logic [31:0] rdata;
    logic sample_req;
    logic keep_awake;
    logic pd_ok;
  } bank_state_s;

  bank_state_s st_ff;
  bank_state_s nxt_st;
  logic [31:0] log_mem [0:255];
  logic mem_we;
  logic [7:0] mem_waddr;
  logic [31:0] mem_wdat;
  logic cfg_hit;
  logic [3:0] cfg_idx;
  logic tick;
  logic running;
  logic [31:0] w_temp, w_trim, w_area, w_timing, w_xlim, w_ylim, w_xnorm, w_ynorm, w_cap, w_calib;
  logic [11:0] temp_corr;
  logic [11:0] temp_avg;
  logic [15:0] smp_target;
  logic t_above, t_below, x_above, x_below, y_above, y_below;
  logic x_out, y_out;
  logic [7:0] x_norm, y_norm;
  logic [8:0] log_addr9;
  logic [8:0] rec_addr9;
  logic irq_go;
  logic log_go;
  logic [31:0] status_word;
  logic [31:0] read_word;

  // ==========================================================================
  // parameter check
  if (TICK_CYCLES_P < 1 || TICK_CYCLES_P >= (longint'(1) << TICK_W)) begin : g_bad_tick
    $error("tick length does not fit the divider");
  end

  // configuration word views
  assign w_temp = st_ff.cfg[CI_TEMP];
  assign w_trim = st_ff.cfg[CI_TRIM];
  assign w_area = st_ff.cfg[CI_AREA];
  assign w_timing = st_ff.cfg[CI_TIMING];
  assign w_xlim = st_ff.cfg[CI_XLIM];
  assign w_ylim = st_ff.cfg[CI_YLIM];
  assign w_xnorm = st_ff.cfg[CI_XNORM];
  assign w_ynorm = st_ff.cfg[CI_YNORM];
  assign w_cap = st_ff.cfg[CI_CAP];
  assign w_calib = st_ff.cfg[CI_CALIB];

  // ==========================================================================
  // measurement datapath
  // offset correction, sign bit set means add
  assign temp_corr = w_trim[OFFS_SIGN_BIT] ? temp_raw + w_trim[HI12_MSB:HI12_LSB]
                                           : temp_raw - w_trim[HI12_MSB:HI12_LSB]; // see R4
  assign smp_target = 16'h0001 << w_area[AVG_EXP_MSB:AVG_EXP_LSB]; // see R9
  assign temp_avg = 12'(st_ff.acc >> w_area[AVG_EXP_MSB:AVG_EXP_LSB]); // see R9

  // temperature bound check on the averaged value
  limit_window #(.WIDTH(12)) u_temp_win (
    .value(temp_avg),
    .upper({4'h0, w_temp[31:UPPER_BOUND_LSB]}), // see R1
    .lower({3'h0, w_temp[LOWER_BOUND_MSB:LOWER_BOUND_LSB]}), // see R1
    .above(t_above),
    .below(t_below)
  );

  // external sensor limit checks
  limit_window #(.WIDTH(12)) u_x_win (
    .value(x_raw),
    .upper(w_xlim[HI12_MSB:HI12_LSB]), // see R13
    .lower(w_xlim[LO12_MSB:0]), // see R13
    .above(x_above),
    .below(x_below)
  );

  limit_window #(.WIDTH(12)) u_y_win (
    .value(y_raw),
    .upper(w_ylim[HI12_MSB:HI12_LSB]), // see R14
    .lower(w_ylim[LO12_MSB:0]), // see R14
    .above(y_above),
    .below(y_below)
  );

  // normalised extremes for the interrupt records
  sensor_normaliser #(.IN_W(12), .OUT_W(8), .FRAC(NORM_FRAC_BITS)) u_x_norm (
    .raw(x_raw),
    .gain(w_xnorm[HI12_MSB:HI12_LSB]), // see R15
    .offset(w_xnorm[LO12_MSB:0]), // see R15
    .result(x_norm)
  );

  sensor_normaliser #(.IN_W(12), .OUT_W(8), .FRAC(NORM_FRAC_BITS)) u_y_norm (
    .raw(y_raw),
    .gain(w_ynorm[HI12_MSB:HI12_LSB]), // see R16
    .offset(w_ynorm[LO12_MSB:0]), // see R16
    .result(y_norm)
  );

  // ==========================================================================
  // decode and helpers
  assign cfg_hit = mem_wr && mem_addr >= ADDR_FLAGS && mem_addr <= ADDR_CALIB;
  assign cfg_idx = 4'(mem_addr - ADDR_FLAGS);
  assign tick = st_ff.tick_div == TICK_W'(TICK_CYCLES_P - 1);
  assign running = st_ff.st == ST_WAIT || st_ff.st == ST_SAMPLE;
  assign x_out = x_above || x_below;
  assign y_out = y_above || y_below;
  // log words sit after the reserved record area
  assign log_addr9 = {1'b0, ADDR_RECORDS} + {1'b0, w_area[31:BYTE3_LSB]} + {1'b0, st_ff.mon_cnt}; // see R21
  assign rec_addr9 = {1'b0, ADDR_RECORDS} + {1'b0, st_ff.irq_cnt};
  // one record per excursion, only while record slots remain
  assign irq_go = running && st_ff.cfg[0][FLAG_IRQ_MODE_BIT] && ext_valid
                  && ((st_ff.cfg[0][FLAG_X_EN_BIT] && x_out && !st_ff.x_prev)
                      || (st_ff.cfg[0][FLAG_Y_EN_BIT] && y_out && !st_ff.y_prev))
                  && st_ff.irq_cnt < w_area[31:BYTE3_LSB] // see R6
                  && rec_addr9 <= {1'b0, ADDR_TOP};
  // log write waits a cycle when a record takes the memory port
  assign log_go = st_ff.st == ST_SAMPLE && st_ff.smp_cnt == smp_target && !irq_go;
  assign status_word = {8'h00, st_ff.irq_cnt, st_ff.st != ST_IDLE, running, st_ff.overflow, 1'b0,
                        st_ff.batt_err, st_ff.alarm, st_ff.outband, st_ff.ext_irq, st_ff.mon_cnt};

  // read mux, unmapped and user words answer zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (mem_addr == ADDR_STATUS) begin
      read_word = status_word;
    end else if (mem_addr >= ADDR_FLAGS && mem_addr <= ADDR_CALIB) begin
      read_word = st_ff.cfg[cfg_idx]; // see R25
    end else if (mem_addr >= ADDR_RECORDS && mem_addr <= w_area[7:0]) begin
      read_word = log_mem[mem_addr]; // see R21
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    mem_we = 1'b0;
    mem_waddr = 8'h00;
    mem_wdat = 32'h0000_0000;
    nxt_st.tick_div = tick ? '0 : st_ff.tick_div + 1'b1;
    nxt_st.batt_s1 = battery_ok;
    nxt_st.batt_s2 = st_ff.batt_s1;
    if (mem_rd) begin
      nxt_st.rdata = read_word;
    end
    // configuration write, reserved bits dropped, status cleared
    if (cfg_hit) begin
      nxt_st.cfg[cfg_idx] = mem_wdata & CFG_MASK[cfg_idx]; // see R25
      nxt_st.irq_cnt = 8'h00; // see R22
      nxt_st.overflow = 1'b0; // see R22
      nxt_st.batt_err = 1'b0; // see R22
      nxt_st.outband = 1'b0; // see R22
      nxt_st.ext_irq = 1'b0; // see R22
      nxt_st.mon_cnt = 8'h00; // see R22
    end
    // monitor sequence, events after the clear so that they win
    unique case (st_ff.st)
      ST_IDLE: begin
        if (start_cmd) begin
          if (!w_trim[SKIP_BATT_BIT] && !st_ff.batt_s2) begin
            nxt_st.batt_err = 1'b1; // see R3
          end else begin
            nxt_st.st = ST_DELAY;
            nxt_st.delay_cnt = 16'h0000;
            nxt_st.outband = start_outband;
          end
        end
      end
      ST_DELAY: begin
        if (st_ff.delay_cnt == w_timing[31:START_DELAY_LSB]) begin
          nxt_st.st = ST_WAIT; // see R11
          nxt_st.minutes = 8'h00;
        end else if (tick) begin
          nxt_st.delay_cnt = st_ff.delay_cnt + 1'b1; // see R11
        end
      end
      ST_WAIT: begin
        if (tick && st_ff.minutes + 8'h01 >= w_timing[7:0] && st_ff.cfg[0][FLAG_TEMP_EN_BIT]) begin
          nxt_st.st = ST_SAMPLE; // see R12
          nxt_st.acc = '0;
          nxt_st.smp_cnt = 16'h0000;
        end
      end
      ST_SAMPLE: begin
        if (log_go) begin
          nxt_st.st = ST_WAIT;
          if (!st_ff.outband || t_above || t_below) begin // see R23
            if (log_addr9 > {1'b0, w_area[7:0]}) begin
              nxt_st.overflow = 1'b1; // see R10
              nxt_st.st = ST_IDLE;
            end else begin
              mem_we = 1'b1;
              mem_waddr = log_addr9[7:0];
              mem_wdat = {8'h00, st_ff.ivl_idx, 4'h0, temp_avg};
              nxt_st.mon_cnt = st_ff.mon_cnt + 1'b1;
            end
          end
        end else if (temp_valid && st_ff.smp_cnt != smp_target) begin
          nxt_st.acc = st_ff.acc + {15'h0000, temp_corr}; // see R9
          nxt_st.smp_cnt = st_ff.smp_cnt + 1'b1;
        end
      end
    endcase
    // interval minute counter keeps running while sampling
    if (running && tick) begin
      if (st_ff.minutes + 8'h01 >= w_timing[7:0]) begin
        nxt_st.minutes = 8'h00; // see R12
        nxt_st.ivl_idx = st_ff.ivl_idx + 1'b1;
      end else begin
        nxt_st.minutes = st_ff.minutes + 1'b1;
      end
    end
    // interrupt record takes the memory port first
    if (ext_valid) begin
      nxt_st.x_prev = x_out;
      nxt_st.y_prev = y_out;
    end
    if (irq_go) begin
      mem_we = 1'b1;
      mem_waddr = rec_addr9[7:0];
      mem_wdat = {st_ff.mon_cnt, st_ff.minutes, y_norm, x_norm}; // see R20
      nxt_st.irq_cnt = st_ff.irq_cnt + 1'b1;
      nxt_st.ext_irq = 1'b1; // see R24
    end
    // pin side levels
    nxt_st.alarm = nxt_st.mon_cnt > nxt_st.cfg[CI_AREA][23:BYTE2_LSB]; // see R7
    nxt_st.keep_awake = nxt_st.cfg[CI_AREA][KEEP_AWAKE_BIT]; // see R8
    nxt_st.pd_ok = !nxt_st.cfg[CI_AREA][KEEP_AWAKE_BIT] && nxt_st.st == ST_IDLE; // see R8
    nxt_st.sample_req = nxt_st.st == ST_SAMPLE && nxt_st.smp_cnt != smp_target;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      st_ff.st <= ST_IDLE;
      st_ff.cfg <= {CFG_WORDS{CFG_RESET}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // record and log storage, no reset needed
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      log_mem[mem_waddr] <= mem_wdat;
    end
  end

  // outputs straight from flip-flops
  assign mem_rdata = st_ff.rdata;
  assign sample_req = st_ff.sample_req;
  assign alarm_pull_low = st_ff.alarm; // see R7
  assign keep_awake = st_ff.keep_awake;
  assign power_down_ok = st_ff.pd_ok;
  assign clock_freq_trim = w_temp[15:BYTE1_LSB]; // see R2
  assign clock_temp_trim = w_temp[7:0]; // see R2
  assign osc_trim_a = w_trim[7:0]; // see R5
  assign osc_trim_b = w_trim[15:BYTE1_LSB]; // see R5
  assign y_neg_cap = w_cap[Y_NEG_CAP_LSB+CAP_FIELD_W-1:Y_NEG_CAP_LSB]; // see R17
  assign y_pos_cap = w_cap[Y_POS_CAP_LSB+CAP_FIELD_W-1:Y_POS_CAP_LSB]; // see R17
  assign x_pos_cap = w_cap[X_POS_CAP_LSB+CAP_FIELD_W-1:X_POS_CAP_LSB]; // see R18
  assign x_neg_cap = w_cap[CAP_FIELD_W-1:0]; // see R18
  assign y_calibration = w_calib[HI12_MSB:HI12_LSB]; // see R19
  assign x_calibration = w_calib[LO12_MSB:0]; // see R19

  // ==========================================================================
  // checks
  // a config write with no event in the same cycle, since events win over the clear
  sequence cfg_write_s;
    cfg_hit && !mem_we && !log_go && !(st_ff.st == ST_IDLE && start_cmd);
  endsequence

  // record lands in the memory, then flag and count show it
  sequence record_written_s;
    mem_we ##1 st_ff.ext_irq && st_ff.irq_cnt != 8'h00;
  endsequence

  sequence blocked_start_s;
    st_ff.st == ST_IDLE && start_cmd && !w_trim[SKIP_BATT_BIT] && !st_ff.batt_s2;
  endsequence

  chk_status_clear: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R22
    cfg_write_s |=> st_ff.mon_cnt == 8'h00 && st_ff.overflow == 1'b0 && !st_ff.batt_err)
    else $error("status not cleared after config write");

  chk_alarm_level: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R7
    alarm_pull_low == (st_ff.mon_cnt > w_area[23:16]))
    else $error("alarm level disagrees with count and threshold");

  chk_log_bound: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R10
    mem_we && !irq_go |-> mem_waddr <= w_area[7:0] && mem_waddr >= ADDR_RECORDS)
    else $error("log write outside the log area");

  chk_batt_block: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R3
    blocked_start_s |=> st_ff.st == ST_IDLE && st_ff.batt_err)
    else $error("start not refused on failed battery test");

  chk_delay_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R11
    st_ff.st == ST_DELAY && st_ff.delay_cnt != w_timing[31:16] && !cfg_hit |=> st_ff.st == ST_DELAY)
    else $error("monitoring began before the start delay ended");

  chk_record_flag: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R24
    irq_go |-> record_written_s)
    else $error("record written without slot or flag");

  chk_keep_awake: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R8
    keep_awake |-> !power_down_ok)
    else $error("power down allowed while serial path kept awake");

  chk_outband_only: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R23
    mem_we && !irq_go && st_ff.outband |-> t_above || t_below)
    else $error("outband logged an in-bounds sample");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R25
    mem_rd && mem_addr >= ADDR_FLAGS && mem_addr <= ADDR_CALIB ##1 1'b1
    |-> (mem_rdata & ~CFG_MASK[4'($past(mem_addr) - ADDR_FLAGS)]) == 32'h0000_0000)
    else $error("reserved bits read back non-zero");

  chk_sample_count: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R9
    st_ff.st == ST_SAMPLE |-> st_ff.smp_cnt <= smp_target)
    else $error("more samples taken than the averaging exponent allows");
endmodule

// *** hw/sensor_normaliser.sv ***
// Purpose: maps a raw sensor reading onto a saturated narrow result
// Assumes: gain is unsigned fixed point with FRAC fractional bits
// Notes: readings below the offset give zero
`timescale 1ns/100ps
module sensor_normaliser #(
  parameter int IN_W = 12,
  parameter int OUT_W = 8,
  parameter int FRAC = 8
) (
  input wire logic [IN_W-1:0] raw,
  input wire logic [IN_W-1:0] gain,
  input wire logic [IN_W-1:0] offset,
  output logic [OUT_W-1:0] result
);
  logic [IN_W-1:0] diff;
  logic [2*IN_W-1:0] prod;
  logic [2*IN_W-1:0] scaled;

  // ==========================================================================
  // parameter check
  if (OUT_W > IN_W || FRAC >= 2 * IN_W) begin : g_bad_width
    $error("sensor_normaliser widths not supported");
  end

  // subtract offset, scale by gain, clip to the output range
  always_comb begin
    diff = (raw > offset) ? raw - offset : '0;
    prod = diff * gain;
    scaled = prod >> FRAC;
    result = (scaled > {{(2*IN_W-OUT_W){1'b0}}, {OUT_W{1'b1}}}) ? {OUT_W{1'b1}} : scaled[OUT_W-1:0];
  end
endmodule

// *** verif/sensor_monitor_config_bank_tb_top.sv ***
// Purpose: self-checking bench for the sensor monitor configuration bank
// Assumes: one-minute tick shortened to 10 cycles of ref_clk
// Notes: y sensor input held idle, x sensor drives one interrupt record
`timescale 1ns/100ps
module sensor_monitor_config_bank_tb_top;
  import monitor_cfg_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [7:0] mem_addr = 8'h00;
  logic [31:0] mem_wdata = 32'h0000_0000;
  logic [31:0] mem_rdata, rd_val;
  logic start_cmd = 1'b0;
  logic temp_valid = 1'b0;
  logic [11:0] temp_raw = 12'h000;
  logic start_outband = 1'b0;
  logic battery_ok = 1'b0;
  logic ext_valid = 1'b0;
  logic [11:0] x_raw = 12'h000;
  logic sample_req, alarm_pull_low, keep_awake, power_down_ok;
  logic [7:0] clock_freq_trim, clock_temp_trim, osc_trim_a, osc_trim_b;
  logic [CAP_FIELD_W-1:0] x_pos_cap, x_neg_cap, y_pos_cap, y_neg_cap;
  logic [11:0] x_calibration, y_calibration;
  int fail_count = 0;
  int checked = 0;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  sensor_monitor_config_bank #(.TICK_CYCLES_P(10)) i_sensor_monitor_config_bank (
    .ref_clk(ref_clk), .arst_n(arst_n), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .start_cmd(start_cmd), .start_outband(start_outband),
    .battery_ok(battery_ok), .temp_raw(temp_raw), .temp_valid(temp_valid), .x_raw(x_raw), .y_raw(12'h000),
    .ext_valid(ext_valid), .sample_req(sample_req), .alarm_pull_low(alarm_pull_low), .keep_awake(keep_awake),
    .power_down_ok(power_down_ok), .clock_freq_trim(clock_freq_trim), .clock_temp_trim(clock_temp_trim),
    .osc_trim_a(osc_trim_a), .osc_trim_b(osc_trim_b), .x_pos_cap(x_pos_cap), .x_neg_cap(x_neg_cap),
    .y_pos_cap(y_pos_cap), .y_neg_cap(y_neg_cap), .x_calibration(x_calibration), .y_calibration(y_calibration));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) #1;
    mem_wr = 1'b1;
    mem_addr = a;
    mem_wdata = d;
    @(posedge ref_clk) #1;
    mem_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) #1;
    mem_rd = 1'b1;
    mem_addr = a;
    @(posedge ref_clk) #1;
    mem_rd = 1'b0;
    rd_val = mem_rdata;
  endtask

  task automatic start();
    @(posedge ref_clk) #1;
    start_cmd = 1'b1;
    @(posedge ref_clk) #1;
    start_cmd = 1'b0;
  endtask

  // wait for the averager to ask, then hand it one sample
  task automatic feed(input logic [11:0] v);
    int n;
    for (n = 0; n < 200 && sample_req !== 1'b1; n++) @(posedge ref_clk) #1;
    if (sample_req !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
    temp_raw = v;
    temp_valid = 1'b1;
    @(posedge ref_clk) #1;
    temp_valid = 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  // reset value and writable bits of every configuration word
  task automatic t_masks();
    for (int i = 0; i < CFG_WORDS; i++) begin
      rd(ADDR_FLAGS + 8'(i));
      check(rd_val, CFG_RESET);
      wr(ADDR_FLAGS + 8'(i), 32'hffff_ffff);
      rd(ADDR_FLAGS + 8'(i));
      check(rd_val, CFG_MASK[i]);
    end
    check(32'(keep_awake), 32'h1);
    check(32'(power_down_ok), 32'h0);
  endtask

  // status write ignored, low words and words past log end read zero
  task automatic t_refused();
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd(ADDR_STATUS);
    check(rd_val, 32'h0000_0000);
    rd(8'h05);
    check(rd_val, 32'h0000_0000);
    wr(ADDR_AREA, 32'h0000_0020);
    rd(8'h30);
    check(rd_val, 32'h0000_0000);
    check(32'(power_down_ok), 32'h1);
  endtask

  // trim, capacitance and calibration fields reach their outputs
  task automatic t_outputs();
    wr(ADDR_TEMP, 32'h1234_5678);
    wr(ADDR_TRIM, 32'h0000_abcd);
    wr(ADDR_CAP, 32'h7f5a_3c41);
    wr(ADDR_CALIB, 32'h0abc_0123);
    @(posedge ref_clk) #1;
    check({osc_trim_b, osc_trim_a, clock_freq_trim, clock_temp_trim}, 32'habcd_5678);
    check({4'h0, y_neg_cap, y_pos_cap, x_pos_cap, x_neg_cap}, {4'h0, 7'h7f, 7'h5a, 7'h3c, 7'h41});
    check({4'h0, y_calibration, 4'h0, x_calibration}, 32'h0abc_0123);
  endtask

  // bad battery blocks start, a config write clears the error
  task automatic t_battery();
    start();
    rd(ADDR_STATUS);
    check(rd_val & 32'h0000_8800, 32'h0000_0800);
    wr(ADDR_TIMING, 32'h0000_0001);
    rd(ADDR_STATUS);
    check(rd_val & 32'h0000_0800, 32'h0000_0000);
  endtask

  // continuous run, battery test skipped, offset added, one sample logged
  task automatic t_monitor();
    wr(ADDR_FLAGS, 32'h0000_0001);
    wr(ADDR_TRIM, 32'h3005_0000);
    start();
    feed(12'h100);
    for (int n = 0; n < 50; n++) begin
      rd(ADDR_STATUS);
      if (rd_val[7:0] !== 8'h00) break;
    end
    check(rd_val & 32'h0000_80ff, 32'h0000_8001);
    rd(ADDR_RECORDS);
    check(rd_val & 32'h0000_0fff, 32'h0000_0105);
    check(32'(alarm_pull_low), 32'h1);
  endtask

  // mid-run reset, good battery, outband run with one x interrupt record
  task automatic t_outband();
    @(posedge ref_clk) #1;
    arst_n = 1'b0;
    battery_ok = 1'b1;
    start_outband = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    wr(ADDR_FLAGS, 32'h0000_000b);
    wr(ADDR_AREA, 32'h0100_0020);
    wr(ADDR_TIMING, 32'h0000_0001);
    wr(ADDR_TEMP, 32'h1008_0000);
    wr(ADDR_XNORM, 32'h0100_0000);
    start();
    feed(12'h00c);
    x_raw = 12'h0ab;
    ext_valid = 1'b1;
    @(posedge ref_clk) #1;
    ext_valid = 1'b0;
    rd(ADDR_STATUS);
    check(rd_val & 32'h00ff_8bff, 32'h0001_8300);
    rd(ADDR_RECORDS);
    check(rd_val, 32'h0000_00ab);
    feed(12'h020);
    rd(8'h1d);
    check(rd_val & 32'h0000_0fff, 32'h0000_0020);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    t_masks();
    t_refused();
    t_outputs();
    t_battery();
    t_monitor();
    t_outband();
    end_of_test();
  end
endmodule
